// ### core/qws_defs.vh
// Constants of the quad wiper serial slave
`ifndef QWS_DEFS_VH
`define QWS_DEFS_VH

// Opcode field of the instruction byte
`define QWS_OP_RD_WIPER   4'h9
`define QWS_OP_WR_WIPER   4'ha
`define QWS_OP_RD_STORED  4'hb
`define QWS_OP_WR_STORED  4'hc
`define QWS_OP_S2W        4'hd
`define QWS_OP_W2S        4'he
`define QWS_OP_G_S2W      4'h1
`define QWS_OP_G_W2S      4'h8
`define QWS_OP_STEP       4'h2

// Field positions of the instruction byte
`define QWS_INS_OP_HI     7
`define QWS_INS_OP_LO     4
`define QWS_INS_REG_HI    3
`define QWS_INS_REG_LO    2
`define QWS_INS_POT_HI    1
`define QWS_INS_POT_LO    0

// Field positions of the identification byte
`define QWS_ID_TYPE_HI    7
`define QWS_ID_TYPE_LO    4
`define QWS_ID_ADDR_HI    3
`define QWS_ID_ADDR_LO    0

// Reset values and wiper limits
`define QWS_STORED_RESET  8'h00
`define QWS_WIPER_RESET   8'h00
`define QWS_WIPER_MAX     8'hff
`define QWS_WIPER_MIN     8'h00

// Timing
`define QWS_NV_WRITE_MS   10
`define QWS_CLOCK_KHZ     100000

`endif

// ### core/qws_slave.v
// Two-wire slave and register store for four wiper positions
`timescale 1ns/100ps
`include "qws_defs.vh"

// Notes on behaviour
// - Write protect low blocks stored writes
// - Eight-bit wiper selects one of 256 taps
// - Four independent wiper position registers
// - Wiper set by write, copy, or step
// - Power-up loads wiper from stored zero
// - Wiper contents are volatile
// - Four stored registers per unit, copyable
// - Stored change takes up to 10 ms
// - Stored registers hold full 0..255
// - Device is slave; master drives clock
// - START then identification byte, MSB first
// - Data changes only while clock low
// - Data pin released after power-up
// - Ignore everything until START seen
// - STOP ends transfer; after read, standby
// - Release after eight bits; ninth acknowledges
// - Acknowledge identification, instruction, write data
// - Identification matches type code and straps
// - Read continues on acknowledge, else stops
// - Busy: ignore bus, no identification acknowledge
// - Upper nibble opcode, next two register select
// - Low two bits select the unit
// - Sample on clock rise, shift after fall
// - Step: data high up, low down
// - Nine opcodes with fixed codes
module qws_slave #(
    parameter [3:0] DEVICE_TYPE     = 4'ha,  // Arbitrary value
    parameter       NV_WRITE_CYCLES = `QWS_NV_WRITE_MS * `QWS_CLOCK_KHZ,
    parameter       FIFO_WIDTH      = 16,
    parameter       FIFO_DEPTH      = 2,
    parameter       FIFO_AW         = 1
) (
    // Clock and reset
    input  wire            clock,
    input  wire            reset,
    // Two-wire bus
    input  wire            scl_in,
    input  wire            sda_in,
    output wire            sda_out,
    output wire            sda_oe,
    // Straps and protection
    input  wire [3:0]      strap_select_pins,
    input  wire            write_protect_n,
    // Wiper outputs
    output wire [31:0]     wiper_position,
    output wire [1023:0]   tap_select,
    // Status
    output wire            nv_busy,
    output wire            standby
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ID   = 4'h1;
    localparam [3:0] S_AID  = 4'h2;
    localparam [3:0] S_INS  = 4'h3;
    localparam [3:0] S_AINS = 4'h4;
    localparam [3:0] S_WDAT = 4'h5;
    localparam [3:0] S_ADAT = 4'h6;
    localparam [3:0] S_TX   = 4'h7;
    localparam [3:0] S_RACK = 4'h8;
    localparam [3:0] S_STEP = 4'h9;
    localparam [3:0] S_IGN  = 4'ha;

    function [3:0] store_index;
        input [1:0] pot;
        input [1:0] sel;
        begin
            store_index = {pot, sel};
        end
    endfunction

    function known_op;
        input [3:0] op;
        begin
            case (op)
                `QWS_OP_RD_WIPER, `QWS_OP_WR_WIPER, `QWS_OP_RD_STORED,
                `QWS_OP_WR_STORED, `QWS_OP_S2W, `QWS_OP_W2S,
                `QWS_OP_G_S2W, `QWS_OP_G_W2S, `QWS_OP_STEP: known_op = 1'b1;
                default: known_op = 1'b0;
            endcase
        end
    endfunction

    // Pin synchronisers
    reg        scl_m;
    reg        scl_s;
    reg        scl_p;
    reg        sda_m;
    reg        sda_s;
    reg        sda_p;
    reg        wp_m;
    reg        wp_s;
    reg  [3:0] strap_m;
    reg  [3:0] strap_s;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            scl_m   <= 1'b1;
            scl_s   <= 1'b1;
            scl_p   <= 1'b1;
            sda_m   <= 1'b1;
            sda_s   <= 1'b1;
            sda_p   <= 1'b1;
            wp_m    <= 1'b0;
            wp_s    <= 1'b0;
            strap_m <= 4'h0;
            strap_s <= 4'h0;
        end else begin
            scl_m   <= scl_in;
            scl_s   <= scl_m;
            scl_p   <= scl_s;
            sda_m   <= sda_in;
            sda_s   <= sda_m;
            sda_p   <= sda_s;
            wp_m    <= write_protect_n;
            wp_s    <= wp_m;
            strap_m <= strap_select_pins;
            strap_s <= strap_m;
        end
    end

    reg         busy;
    wire        stop_det   = scl_s & scl_p & ~sda_p & sda_s;
    wire        start_det  = ~busy & scl_s & scl_p & sda_p & ~sda_s;
    wire        stop_seen  = ~busy & stop_det;
    wire        scl_rise   = ~busy & scl_s & ~scl_p;
    wire        scl_fall   = ~busy & ~scl_s & scl_p;

    // Storage
    reg  [7:0]  wiper  [0:3];
    reg  [7:0]  stored [0:15];

    // Two-entry command buffer
    reg  [FIFO_WIDTH-1:0] fifo_mem [0:FIFO_DEPTH-1];
    reg  [FIFO_AW-1:0]    fifo_wp;
    reg  [FIFO_AW-1:0]    fifo_rp;
    reg  [FIFO_AW:0]      fifo_cnt;
    reg                   push;
    reg  [FIFO_WIDTH-1:0] push_data;
    reg                   load_pending;
    wire                  fifo_in_ready  = (fifo_cnt != FIFO_DEPTH[FIFO_AW:0]);
    wire                  fifo_out_valid = (fifo_cnt != {(FIFO_AW+1){1'b0}});
    wire                  exec_ready     = ~load_pending;
    wire                  pop            = fifo_out_valid & exec_ready;
    wire                  do_push        = push & fifo_in_ready;
    wire [FIFO_WIDTH-1:0] head           = fifo_mem[fifo_rp];

    integer i;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            fifo_wp  <= {FIFO_AW{1'b0}};
            fifo_rp  <= {FIFO_AW{1'b0}};
            fifo_cnt <= {(FIFO_AW+1){1'b0}};
            for (i = 0; i < FIFO_DEPTH; i = i + 1)
                fifo_mem[i] <= {FIFO_WIDTH{1'b0}};
        end else begin
            if (do_push) begin
                fifo_mem[fifo_wp] <= push_data;
                fifo_wp           <= fifo_wp + 1'b1;
            end
            if (pop)
                fifo_rp <= fifo_rp + 1'b1;
            if (do_push & ~pop)
                fifo_cnt <= fifo_cnt + 1'b1;
            else if (pop & ~do_push)
                fifo_cnt <= fifo_cnt - 1'b1;
        end
    end

    // Serial engine
    reg  [3:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  rx_sh;
    reg  [7:0]  tx_sh;
    reg  [7:0]  instr;
    reg         acked;
    reg         read_seen;
    reg         oe_q;
    reg         standby_q;
    reg  [7:0]  rd_val;
    wire [3:0]  ins_op  = instr[`QWS_INS_OP_HI:`QWS_INS_OP_LO];
    wire [3:0]  new_op  = rx_sh[`QWS_INS_OP_HI:`QWS_INS_OP_LO];
    wire [1:0]  ins_reg = instr[`QWS_INS_REG_HI:`QWS_INS_REG_LO];
    wire [1:0]  ins_pot = instr[`QWS_INS_POT_HI:`QWS_INS_POT_LO];
    wire        id_match = (rx_sh[`QWS_ID_TYPE_HI:`QWS_ID_TYPE_LO] == DEVICE_TYPE) &
                           (rx_sh[`QWS_ID_ADDR_HI:`QWS_ID_ADDR_LO] == strap_s);

    always @* begin
        if (ins_op == `QWS_OP_RD_STORED)
            rd_val = stored[store_index(ins_pot, ins_reg)];
        else
            rd_val = wiper[ins_pot];
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state     <= S_IDLE;
            bit_cnt   <= 4'h0;
            rx_sh     <= 8'h00;
            tx_sh     <= 8'h00;
            instr     <= 8'h00;
            acked     <= 1'b0;
            read_seen <= 1'b0;
            oe_q      <= 1'b0;
            standby_q <= 1'b1;
            push      <= 1'b0;
            push_data <= {FIFO_WIDTH{1'b0}};
        end else begin
            push <= 1'b0;
            if (start_det) begin
                state     <= S_ID;
                bit_cnt   <= 4'h0;
                oe_q      <= 1'b0;
                read_seen <= 1'b0;
                standby_q <= 1'b0;
            end else if (stop_seen) begin
                state <= S_IDLE;
                oe_q  <= 1'b0;
                if (read_seen)
                    standby_q <= 1'b1;
            end else if (scl_rise) begin
                case (state)
                    S_ID, S_INS, S_WDAT: begin
                        rx_sh   <= {rx_sh[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    S_TX:    bit_cnt <= bit_cnt + 4'h1;
                    S_RACK:  acked <= ~sda_s;
                    S_STEP: begin
                        push      <= 1'b1;
                        push_data <= {instr, 7'h00, sda_s};
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ID: if (bit_cnt == 4'h8) begin
                        if (id_match) begin
                            oe_q  <= 1'b1;
                            state <= S_AID;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                    S_AID: begin
                        oe_q    <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= S_INS;
                    end
                    S_INS: if (bit_cnt == 4'h8) begin
                        instr <= rx_sh;
                        if (known_op(new_op) & fifo_in_ready) begin
                            oe_q  <= 1'b1;
                            state <= S_AINS;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                    S_AINS: begin
                        oe_q    <= 1'b0;
                        bit_cnt <= 4'h0;
                        case (ins_op)
                            `QWS_OP_RD_WIPER, `QWS_OP_RD_STORED: begin
                                tx_sh     <= {rd_val[6:0], 1'b0};
                                oe_q      <= ~rd_val[7];
                                read_seen <= 1'b1;
                                state     <= S_TX;
                            end
                            `QWS_OP_WR_WIPER, `QWS_OP_WR_STORED: state <= S_WDAT;
                            `QWS_OP_STEP: state <= S_STEP;
                            default: begin
                                push      <= 1'b1;
                                push_data <= {instr, 8'h00};
                                state     <= S_IGN;
                            end
                        endcase
                    end
                    S_TX: begin
                        if (bit_cnt == 4'h8) begin
                            oe_q  <= 1'b0;
                            state <= S_RACK;
                        end else begin
                            oe_q  <= ~tx_sh[7];
                            tx_sh <= {tx_sh[6:0], 1'b0};
                        end
                    end
                    S_RACK: begin
                        bit_cnt <= 4'h0;
                        if (acked) begin
                            tx_sh <= {rd_val[6:0], 1'b0};
                            oe_q  <= ~rd_val[7];
                            state <= S_TX;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                    S_WDAT: if (bit_cnt == 4'h8) begin
                        if (fifo_in_ready) begin
                            push      <= 1'b1;
                            push_data <= {instr, rx_sh};
                            oe_q      <= 1'b1;
                            state     <= S_ADAT;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                    S_ADAT: begin
                        oe_q    <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= S_WDAT;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Executor and storage updates
    reg         nv_dirty;
    wire        nv_start = stop_det & nv_dirty & ~busy;
    wire [3:0]  x_op     = head[15:12];
    wire [1:0]  x_reg    = head[11:10];
    wire [1:0]  x_pot    = head[9:8];
    wire [7:0]  x_data   = head[7:0];
    wire        nv_ok    = wp_s;
    wire        nv_set   = pop & nv_ok &
                           ((x_op == `QWS_OP_WR_STORED) | (x_op == `QWS_OP_W2S) |
                            (x_op == `QWS_OP_G_W2S));
    integer     k;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            load_pending <= 1'b1;
            nv_dirty     <= 1'b0;
            for (k = 0; k < 4; k = k + 1)
                wiper[k] <= `QWS_WIPER_RESET;
            for (k = 0; k < 16; k = k + 1)
                stored[k] <= `QWS_STORED_RESET;
        end else begin
            if (load_pending) begin
                load_pending <= 1'b0;
                for (k = 0; k < 4; k = k + 1)
                    wiper[k] <= stored[k * 4];
            end else if (pop) begin
                case (x_op)
                    `QWS_OP_WR_WIPER: wiper[x_pot] <= x_data;
                    `QWS_OP_WR_STORED: if (nv_ok) begin
                        stored[store_index(x_pot, x_reg)] <= x_data;
                    end
                    `QWS_OP_S2W: wiper[x_pot] <= stored[store_index(x_pot, x_reg)];
                    `QWS_OP_W2S: if (nv_ok) begin
                        stored[store_index(x_pot, x_reg)] <= wiper[x_pot];
                    end
                    `QWS_OP_G_S2W:
                        for (k = 0; k < 4; k = k + 1)
                            wiper[k] <= stored[k * 4 + x_reg];
                    `QWS_OP_G_W2S: if (nv_ok) begin
                        for (k = 0; k < 4; k = k + 1)
                            stored[k * 4 + x_reg] <= wiper[k];
                    end
                    `QWS_OP_STEP: begin
                        if (x_data[0] && wiper[x_pot] != `QWS_WIPER_MAX)
                            wiper[x_pot] <= wiper[x_pot] + 8'h01;
                        else if (!x_data[0] && wiper[x_pot] != `QWS_WIPER_MIN)
                            wiper[x_pot] <= wiper[x_pot] - 8'h01;
                    end
                    default: ;
                endcase
            end
            if (nv_set)
                nv_dirty <= 1'b1;
            else if (nv_start)
                nv_dirty <= 1'b0;
        end
    end

    // Nonvolatile write timer
    reg [31:0] nv_timer;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            busy     <= 1'b0;
            nv_timer <= 32'h0;
        end else if (nv_start) begin
            busy     <= 1'b1;
            nv_timer <= NV_WRITE_CYCLES[31:0] - 32'h1;
        end else if (busy) begin
            if (nv_timer == 32'h0)
                busy <= 1'b0;
            else
                nv_timer <= nv_timer - 32'h1;
        end
    end

    // Tap decode per wiper
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_tap
            reg [255:0] tap;
            reg [7:0]   pos;
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    tap <= 256'h0;
                    pos <= `QWS_WIPER_RESET;
                end else begin
                    tap <= {248'h0, 8'h01} << wiper[g];
                    pos <= wiper[g];
                end
            end
            assign tap_select[g*256 +: 256]  = tap;
            assign wiper_position[g*8 +: 8]  = pos;
        end
    endgenerate

    // Open-drain data pin only ever pulls low
    reg sda_low;
    always @(posedge clock or posedge reset) begin
        if (reset)
            sda_low <= 1'b0;
        else
            sda_low <= 1'b0;
    end

    assign sda_out = sda_low;
    assign sda_oe  = oe_q;
    assign nv_busy = busy;
    assign standby = standby_q;

endmodule

// ### core/qws_slave_unused_guard.v
// Holds no logic; the whole block lives in qws_slave.v

// ### sim/qws_slave_monitor.sv
// Port checks for the wiper slave, bound to its top module
`timescale 1ns/100ps
module qws_slave_monitor #(
    parameter NV_WRITE_CYCLES = 1000000
) (
    // Clock and reset
    input wire logic          clock,
    input wire logic          reset,
    // Two-wire bus
    input wire logic          scl_in,
    input wire logic          sda_in,
    input wire logic          sda_out,
    input wire logic          sda_oe,
    // Straps and protection
    input wire logic [3:0]    strap_select_pins,
    input wire logic          write_protect_n,
    // Wiper outputs
    input wire logic [31:0]   wiper_position,
    input wire logic [1023:0] tap_select,
    // Status
    input wire logic          nv_busy,
    input wire logic          standby
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    logic [2:0]  settle;
    logic [31:0] busy_len;

    // Settling after reset and length of the stored write
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            settle   <= 3'h0;
            busy_len <= 32'h0;
        end else begin
            settle   <= (settle == 3'h7) ? settle : settle + 3'h1;
            busy_len <= nv_busy ? busy_len + 32'h1 : 32'h0;
        end
    end

    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("data output not low");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    AST_OE_IDLE_BUSY: assert property (nv_busy |-> !sda_oe)
        else $error("data line driven while busy");
    AST_WIPER_HOLD_BUSY: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_position))
        else $error("wiper moved while busy");
    AST_BUSY_LENGTH: assert property ($fell(nv_busy) |-> busy_len == NV_WRITE_CYCLES)
        else $error("busy length wrong");
    AST_BUSY_BOUND: assert property (nv_busy |-> busy_len < NV_WRITE_CYCLES)
        else $error("busy too long");
    AST_WP_BLOCKS: assert property ($rose(nv_busy) |-> write_protect_n && $past(write_protect_n, 8))
        else $error("stored write while protected");
    AST_STANDBY_STOP: assert property ($rose(standby) |-> scl_in && sda_in)
        else $error("standby without stop");
    AST_START_WAKE: assert property ($fell(standby) |-> scl_in && !sda_in)
        else $error("woke without start");

    for (genvar p = 0; p < 4; p++) begin : g_tap
        AST_TAP_MATCH: assert property (settle == 3'h7 && $stable(wiper_position) ##1 $stable(wiper_position) |-> $onehot(tap_select[256*p +: 256]) && tap_select[256*p + wiper_position[8*p +: 8]])
            else $error("tap select does not match wiper");
    end

    cover property ($fell(nv_busy));
    cover property ($rose(sda_oe));
    cover property ($rose(standby));
endmodule

bind qws_slave qws_slave_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_qws_slave_monitor (
    .clock(clock), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_select_pins(strap_select_pins), .write_protect_n(write_protect_n),
    .wiper_position(wiper_position), .tap_select(tap_select), .nv_busy(nv_busy),
    .standby(standby));

// ### sim/qws_bus_master.sv
// Two-wire bus master model for the wiper slave
`timescale 1ns/100ps
module qws_bus_master (
    // Pacing clock
    input  wire logic clock,
    // Bus lines
    input  wire logic sda_line,
    output logic      scl_line,
    output logic      sda_pull_low
);
    initial begin
        scl_line     = 1'b1;
        sda_pull_low = 1'b0;
    end

    // Half of the 160 ns link period
    task automatic half;
        repeat (8) @(posedge clock);
        #1;
    endtask

    // Data set only while clock low
    task automatic put_bit(input logic b);
        sda_pull_low = ~b;
        half();
        scl_line = 1'b1;
        half();
        scl_line = 1'b0;
    endtask

    // Released line sampled while clock high
    task automatic get_bit(output logic b);
        sda_pull_low = 1'b0;
        half();
        scl_line = 1'b1;
        b = sda_line;
        half();
        scl_line = 1'b0;
    endtask

    task automatic start;
        sda_pull_low = 1'b0;
        half();
        scl_line = 1'b1;
        half();
        sda_pull_low = 1'b1;
        half();
        scl_line = 1'b0;
    endtask

    // Line pulled low first, then released while clock high
    task automatic stop;
        sda_pull_low = 1'b1;
        half();
        scl_line = 1'b1;
        half();
        sda_pull_low = 1'b0;
        half();
    endtask

    // Most significant bit first
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        get_bit(n);
        ack = ~n;
    endtask

    // Acknowledge asks for more
    task automatic rd_byte(output logic [7:0] b, input logic more);
        for (int i = 7; i >= 0; i--)
            get_bit(b[i]);
        put_bit(~more);
    endtask
endmodule

// ### sim/qws_slave_tb.sv
// Self-checking bench for the wiper slave
`timescale 1ns/100ps
module qws_slave_tb;
    localparam int         NV_CYC   = 400;
    localparam logic [3:0] DEV_TYPE = 4'ha;  // Arbitrary value
    localparam logic [3:0] STRAPS   = 4'h6;

    logic          clock;
    logic          reset;
    logic          write_protect_n;
    logic [3:0]    strap_select_pins;
    wire           scl_line;
    wire           sda_pull_low;
    wire           sda_out;
    wire           sda_oe;
    wire           nv_busy;
    wire           standby;
    wire  [31:0]   wiper_position;
    wire  [1023:0] tap_select;
    wire           sda_line = (sda_pull_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    int            err_count;
    int            checks_done;

    qws_slave #(.DEVICE_TYPE(DEV_TYPE), .NV_WRITE_CYCLES(NV_CYC)) i_qws_slave (
        .clock(clock), .reset(reset), .scl_in(scl_line), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_pins(strap_select_pins),
        .write_protect_n(write_protect_n), .wiper_position(wiper_position),
        .tap_select(tap_select), .nv_busy(nv_busy), .standby(standby));

    qws_bus_master i_qws_bus_master (
        .clock(clock), .sda_line(sda_line), .scl_line(scl_line),
        .sda_pull_low(sda_pull_low));

    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask

    task automatic chk_wipers(input logic [31:0] exp);
        for (int p = 0; p < 4; p++)
            chk_byte(wiper_position[8*p +: 8], exp[8*p +: 8]);
    endtask

    task automatic open_cmd(input logic [7:0] ins, input logic exp_ack);
        logic a;
        i_qws_bus_master.start();
        chk_bit(standby, 1'b0);
        i_qws_bus_master.wr_byte({DEV_TYPE, STRAPS}, a);
        chk_bit(a, 1'b1);
        i_qws_bus_master.wr_byte(ins, a);
        chk_bit(a, exp_ack);
    endtask

    task automatic write_reg(input logic [7:0] ins, input logic [7:0] d);
        logic a;
        open_cmd(ins, 1'b1);
        i_qws_bus_master.wr_byte(d, a);
        chk_bit(a, 1'b1);
        i_qws_bus_master.stop();
    endtask

    task automatic read_reg(input logic [7:0] ins, input logic [7:0] exp);
        logic [7:0] d;
        open_cmd(ins, 1'b1);
        i_qws_bus_master.rd_byte(d, 1'b1);
        chk_byte(d, exp);
        i_qws_bus_master.rd_byte(d, 1'b0);
        chk_byte(d, exp);
        i_qws_bus_master.stop();
        chk_bit(standby, 1'b1);
        chk_bit(sda_oe, 1'b0);
    endtask

    task automatic wait_nv;
        int n;
        n = 0;
        while (nv_busy === 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        #1;
        chk_bit(nv_busy, 1'b0);
    endtask

    task automatic t_reset;
        repeat (4) @(posedge clock);
        #1;
        chk_wipers(32'h0);
        chk_bit(tap_select[0], 1'b1);
        chk_bit(sda_oe, 1'b0);
        chk_bit(standby, 1'b1);
    endtask

    task automatic t_wiper_rw;
        logic [7:0] v;
        for (int p = 0; p < 4; p++) begin
            v = 8'h30 + 8'h41 * p[7:0];
            write_reg({4'ha, 2'b00, p[1:0]}, v);
            chk_byte(wiper_position[8*p +: 8], v);
            chk_bit(tap_select[256*p + v], 1'b1);
            read_reg({4'h9, 2'b00, p[1:0]}, v);
        end
    endtask

    task automatic t_refuse;
        logic a;
        for (int k = 0; k < 2; k++) begin
            i_qws_bus_master.start();
            i_qws_bus_master.wr_byte(k == 0 ? {~DEV_TYPE, STRAPS} : {DEV_TYPE, ~STRAPS}, a);
            chk_bit(a, 1'b0);
            i_qws_bus_master.stop();
        end
        open_cmd(8'hf0, 1'b0);
        i_qws_bus_master.stop();
        chk_wipers(32'hf3b27130);
    endtask

    task automatic t_stored;
        logic a;
        write_reg(8'hce, 8'ha5);
        chk_bit(nv_busy, 1'b1);
        i_qws_bus_master.start();
        i_qws_bus_master.wr_byte({DEV_TYPE, STRAPS}, a);
        chk_bit(a, 1'b0);
        i_qws_bus_master.stop();
        wait_nv();
        read_reg(8'hbe, 8'ha5);
    endtask

    task automatic t_copy;
        open_cmd(8'hde, 1'b1);
        i_qws_bus_master.stop();
        chk_byte(wiper_position[23:16], 8'ha5);
        chk_bit(nv_busy, 1'b0);
        open_cmd(8'he9, 1'b1);
        i_qws_bus_master.stop();
        chk_bit(nv_busy, 1'b1);
        wait_nv();
        read_reg(8'hb9, 8'h71);
        open_cmd(8'h84, 1'b1);
        i_qws_bus_master.stop();
        wait_nv();
        open_cmd(8'h10, 1'b1);
        i_qws_bus_master.stop();
        chk_wipers(32'h0);
        open_cmd(8'h14, 1'b1);
        i_qws_bus_master.stop();
        chk_wipers(32'hf3a57130);
    endtask

    task automatic t_protect;
        write_protect_n = 1'b0;
        write_reg(8'hc4, 8'h3c);
        chk_bit(nv_busy, 1'b0);
        write_protect_n = 1'b1;
        read_reg(8'hb4, 8'h30);
    endtask

    task automatic t_step;
        write_reg(8'ha0, 8'hfd);
        open_cmd(8'h20, 1'b1);
        repeat (4) i_qws_bus_master.put_bit(1'b1);
        i_qws_bus_master.stop();
        chk_byte(wiper_position[7:0], 8'hfe);
        write_reg(8'ha0, 8'h02);
        open_cmd(8'h20, 1'b1);
        i_qws_bus_master.put_bit(1'b1);
        repeat (5) i_qws_bus_master.put_bit(1'b0);
        i_qws_bus_master.stop();
        chk_byte(wiper_position[7:0], 8'h00);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Tests need about 13000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end

    initial begin
        err_count         = 0;
        checks_done       = 0;
        reset             = 1'b1;
        write_protect_n   = 1'b1;
        strap_select_pins = STRAPS;
        repeat (4) @(posedge clock);
        #1;
        reset = 1'b0;
        t_reset();
        t_wiper_rw();
        t_refuse();
        t_stored();
        t_copy();
        t_protect();
        t_step();
        tally_and_finish();
    end
endmodule
